// >>> src/ptm_pkg.sv
// Package: register map, field positions and types for the periodic timer pair
package ptm_pkg;
  // Word byte addresses on the Wishbone slave
  localparam logic [5:0] PTM_ADR_CTRL0 = 6'h00;
  localparam logic [5:0] PTM_ADR_CTRL1 = 6'h04;
  localparam logic [5:0] PTM_ADR_CNT0 = 6'h08;
  localparam logic [5:0] PTM_ADR_CMPA0 = 6'h0C;
  localparam logic [5:0] PTM_ADR_PER0_LO = 6'h10;
  localparam logic [5:0] PTM_ADR_PER0_HI = 6'h14;
  localparam logic [5:0] PTM_ADR_CNT1 = 6'h18;
  localparam logic [5:0] PTM_ADR_CMPA1 = 6'h1C;
  localparam logic [5:0] PTM_ADR_PER1_LO = 6'h20;
  localparam logic [5:0] PTM_ADR_PER1_HI = 6'h24;
  localparam logic [5:0] PTM_ADR_FLAGS = 6'h28;
  // Control register bit positions
  localparam int PTM_B_CLR = 0;
  localparam int PTM_B_INV = 2;
  localparam int PTM_B_LVL = 3;
  localparam int PTM_B_ACT = 4;
  localparam int PTM_B_MODE = 6;
  localparam int PTM_B_RUN = 8;
  // Flag register positions: per instance, match A then match P
  localparam int PTM_B_AF0 = 0;
  localparam int PTM_B_PF0 = 1;
  localparam int PTM_B_AF1 = 2;
  localparam int PTM_B_PF1 = 3;
  // Reset values, narrow period high-byte mask and channel widths
  localparam logic [8:0] PTM_CTRL_RST = 9'h000;
  localparam logic [15:0] PTM_VAL_RST = 16'h0000;
  localparam logic [7:0] PTM_NARROW_HI_MASK = 8'h03;
  localparam int PTM_WIDE_BITS = 16;
  localparam int PTM_NARROW_BITS = 10;

  typedef enum logic [1:0] {
    PTM_MODE_CMP = 2'b00,
    PTM_MODE_CAP = 2'b01,
    PTM_MODE_PWM = 2'b10,
    PTM_MODE_TMR = 2'b11
  } ptm_mode_t;

  // Control word of one timer
  typedef struct packed {
    logic run;
    ptm_mode_t mode;
    logic [1:0] action;
    logic level;
    logic invert;
    logic unused_b1;
    logic clear_sel;
  } ptm_ctrl_t;

  // Event pulses out of one timer
  typedef struct packed {
    logic match_a;
    logic match_p;
    logic auto_stop;
  } ptm_evt_t;
endpackage

// >>> src/ptm_core.sv
// Single periodic timer channel: counter, comparators and output stage
`timescale 1ns/1ps
module ptm_core import ptm_pkg::*; #(
  parameter int W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire ptm_ctrl_t i_ctrl,
  input wire logic [W-1:0] i_cmp_a,
  input wire logic [W-1:0] i_period,
  output logic [W-1:0] o_count,
  output ptm_evt_t o_evt,
  output logic o_pin
);
  logic [W-1:0] cnt_q, cnt_d;
  logic run_q;
  logic out_q, out_d;
  logic pin_q;
  logic [W-1:0] per_last;
  wire run_rise = i_ctrl.run & ~run_q;
  wire is_pwm = (i_ctrl.mode == PTM_MODE_PWM);
  wire is_single = is_pwm & (i_ctrl.action == 2'b11);
  wire is_cmp = (i_ctrl.mode == PTM_MODE_CMP);
  // Zero compare value disables match A so a counter cleared on match A rolls at full scale
  // A stale count is ignored in the restart cycle of a single pulse
  wire hit_a = i_ctrl.run & ~(run_rise & is_single) & (i_cmp_a != '0) &
               (cnt_q == i_cmp_a - W'(1));
  // Period zero means full-scale count; period value N counts 0..N-1
  assign per_last = i_period - W'(1);
  wire hit_p = i_ctrl.run & (cnt_q == per_last);
  wire ovf = i_ctrl.run & (cnt_q == '1);
  wire clear_on_a = ~is_pwm & i_ctrl.clear_sel;
  wire clr = is_single ? 1'b0 : (clear_on_a ? hit_a : hit_p);

  // Events: P flag suppressed with A-clear and in single pulse
  assign o_evt.match_a = i_ce & hit_a;
  assign o_evt.match_p = i_ce & hit_p & ~clear_on_a & ~is_single & (i_period != '0);
  assign o_evt.auto_stop = i_ce & hit_a & is_single;

  // Counter next value
  always_comb begin
    cnt_d = cnt_q;
    if (run_rise && is_single) begin
      cnt_d = '0;
    end else if (i_ctrl.run) begin
      cnt_d = clr ? '0 : cnt_q + W'(1);
    end
  end

  // Output level next value
  always_comb begin
    out_d = out_q;
    if (run_rise) begin
      out_d = i_ctrl.level;
    end else if (is_cmp && hit_a) begin
      case (i_ctrl.action)
        2'b01: out_d = 1'b0;
        2'b10: out_d = 1'b1;
        2'b11: out_d = ~out_q;
        default: out_d = out_q;
      endcase
    end else if (is_single && (hit_a || !i_ctrl.run)) begin
      out_d = ~i_ctrl.level;
    end
  end

  // PWM waveform: active while count below duty; duty >= a nonzero period is full on
  wire per_zero = (i_period == '0);
  wire full_duty = ~per_zero & (i_cmp_a >= i_period);
  wire pwm_act = full_duty | (cnt_q < i_cmp_a);
  logic act_lvl;
  always_comb begin
    case (i_ctrl.action)
      2'b00: act_lvl = ~i_ctrl.level;
      2'b01: act_lvl = i_ctrl.level;
      2'b10: act_lvl = pwm_act ? i_ctrl.level : ~i_ctrl.level;
      default: act_lvl = out_q;
    endcase
  end
  // Timer/counter mode leaves the pin idle at zero
  wire pin_raw = (i_ctrl.mode == PTM_MODE_TMR) ? 1'b0 :
                 ((is_pwm ? act_lvl : out_q) ^ i_ctrl.invert);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      out_q <= 1'b0;
      pin_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      run_q <= i_ctrl.run;
      out_q <= out_d;
      pin_q <= pin_raw;
    end
  end
  assign o_count = cnt_q;
  assign o_pin = pin_q;
endmodule

// >>> src/ptm_regs.sv
// Wishbone classic slave read multiplexer for the timer pair
`timescale 1ns/1ps
module ptm_regs import ptm_pkg::*; (
  input wire logic [5:0] i_adr,
  input wire logic [8:0] i_ctrl0,
  input wire logic [8:0] i_ctrl1,
  input wire logic [15:0] i_cnt0,
  input wire logic [15:0] i_cmp0,
  input wire logic [15:0] i_per0,
  input wire logic [9:0] i_cnt1,
  input wire logic [9:0] i_cmp1,
  input wire logic [9:0] i_per1,
  input wire logic [3:0] i_flags,
  output logic [31:0] o_rdata,
  output logic o_hit
);
  // Unmapped words read zero and clear o_hit, so the bus answers with an error
  always_comb begin
    o_hit = 1'b1;
    case (i_adr)
      PTM_ADR_CTRL0: o_rdata = {23'h000000, i_ctrl0};
      PTM_ADR_CTRL1: o_rdata = {23'h000000, i_ctrl1};
      PTM_ADR_CNT0: o_rdata = {16'h0000, i_cnt0};
      PTM_ADR_CMPA0: o_rdata = {16'h0000, i_cmp0};
      PTM_ADR_PER0_LO: o_rdata = {24'h000000, i_per0[7:0]};
      PTM_ADR_PER0_HI: o_rdata = {24'h000000, i_per0[15:8]};
      PTM_ADR_CNT1: o_rdata = {22'h000000, i_cnt1};
      PTM_ADR_CMPA1: o_rdata = {22'h000000, i_cmp1};
      PTM_ADR_PER1_LO: o_rdata = {24'h000000, i_per1[7:0]};
      PTM_ADR_PER1_HI: o_rdata = {30'h00000000, i_per1[9:8]};
      PTM_ADR_FLAGS: o_rdata = {28'h0000000, i_flags};
      default: begin
        o_rdata = 32'h00000000;
        o_hit = 1'b0;
      end
    endcase
  end
endmodule

// >>> src/ptm_top.sv
// Periodic timer pair: 16-bit and 10-bit channel behind a Wishbone slave
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module ptm_top import ptm_pkg::*; (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [5:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_WB_ERR,
  output logic O_PIN_WIDE,
  output logic O_PIN_NARROW
);
  ptm_ctrl_t ctrl0_q, ctrl1_q;
  logic [15:0] cmp0_q, per0_q, cnt0;
  logic [9:0] cmp1_q, per1_q, cnt1;
  logic [3:0] flags_q, flags_d;
  logic ack_q, err_q;
  logic [31:0] rdat_q, rdata;
  logic hit;
  ptm_evt_t ev0, ev1;

  // Bus decode: one access per request, answer one cycle later
  wire req = I_WB_CYC & I_WB_STB & ~ack_q & ~err_q;
  wire wr = req & I_WB_WE & hit;
  wire wr_lo = wr & I_WB_SEL[0];
  wire wr_b1 = wr & I_WB_SEL[1];
  wire wr_c0 = wr & (I_WB_ADR == PTM_ADR_CTRL0);
  wire wr_c1 = wr & (I_WB_ADR == PTM_ADR_CTRL1);
  wire wr_fl = wr_lo & (I_WB_ADR == PTM_ADR_FLAGS);

  ptm_regs u_regs (
    .i_adr(I_WB_ADR),
    .i_ctrl0(ctrl0_q),
    .i_ctrl1(ctrl1_q),
    .i_cnt0(cnt0),
    .i_cmp0(cmp0_q),
    .i_per0(per0_q),
    .i_cnt1(cnt1),
    .i_cmp1(cmp1_q),
    .i_per1(per1_q),
    .i_flags(flags_q),
    .o_rdata(rdata),
    .o_hit(hit)
  );

  // Flags: write one clears, hardware set wins over the clear
  always_comb begin
    flags_d = flags_q & ~(wr_fl ? I_WB_DAT[3:0] : 4'h0);
    flags_d[PTM_B_AF0] = flags_d[PTM_B_AF0] | ev0.match_a;
    flags_d[PTM_B_PF0] = flags_d[PTM_B_PF0] | ev0.match_p;
    flags_d[PTM_B_AF1] = flags_d[PTM_B_AF1] | ev1.match_a;
    flags_d[PTM_B_PF1] = flags_d[PTM_B_PF1] | ev1.match_p;
  end

  // Bus handshake and read data capture
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else if (I_CE) begin
      ack_q <= req & hit;
      err_q <= req & ~hit;
      rdat_q <= req ? rdata : 32'h00000000;
    end
  end

  // Control words; a single pulse match drops run even under a write
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ctrl0_q <= PTM_CTRL_RST;
      ctrl1_q <= PTM_CTRL_RST;
    end else if (I_CE) begin
      if (wr_c0 && I_WB_SEL[0]) ctrl0_q[7:0] <= I_WB_DAT[7:0];
      if (wr_c0 && I_WB_SEL[1]) ctrl0_q.run <= I_WB_DAT[PTM_B_RUN];
      if (ev0.auto_stop) ctrl0_q.run <= 1'b0;
      if (wr_c1 && I_WB_SEL[0]) ctrl1_q[7:0] <= I_WB_DAT[7:0];
      if (wr_c1 && I_WB_SEL[1]) ctrl1_q.run <= I_WB_DAT[PTM_B_RUN];
      if (ev1.auto_stop) ctrl1_q.run <= 1'b0;
    end
  end

  // Compare and period values, byte lane writes
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cmp0_q <= PTM_VAL_RST;
      per0_q <= PTM_VAL_RST;
      cmp1_q <= PTM_VAL_RST[9:0];
      per1_q <= PTM_VAL_RST[9:0];
    end else if (I_CE) begin
      if (wr_lo && I_WB_ADR == PTM_ADR_CMPA0) cmp0_q[7:0] <= I_WB_DAT[7:0];
      if (wr_b1 && I_WB_ADR == PTM_ADR_CMPA0) cmp0_q[15:8] <= I_WB_DAT[15:8];
      if (wr_lo && I_WB_ADR == PTM_ADR_PER0_LO) per0_q[7:0] <= I_WB_DAT[7:0];
      if (wr_lo && I_WB_ADR == PTM_ADR_PER0_HI) per0_q[15:8] <= I_WB_DAT[7:0];
      if (wr_lo && I_WB_ADR == PTM_ADR_CMPA1) cmp1_q[7:0] <= I_WB_DAT[7:0];
      if (wr_b1 && I_WB_ADR == PTM_ADR_CMPA1) cmp1_q[9:8] <= I_WB_DAT[9:8];
      if (wr_lo && I_WB_ADR == PTM_ADR_PER1_LO) per1_q[7:0] <= I_WB_DAT[7:0];
      if (wr_lo && I_WB_ADR == PTM_ADR_PER1_HI) begin
        per1_q[9:8] <= I_WB_DAT[1:0] & PTM_NARROW_HI_MASK[1:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) flags_q <= 4'h0;
    else if (I_CE) flags_q <= flags_d;
  end

  ptm_core #(.W(PTM_WIDE_BITS)) u_wide (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_ctrl(ctrl0_q),
    .i_cmp_a(cmp0_q),
    .i_period(per0_q),
    .o_count(cnt0),
    .o_evt(ev0),
    .o_pin(O_PIN_WIDE)
  );

  ptm_core #(.W(PTM_NARROW_BITS)) u_narrow (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_ctrl(ctrl1_q),
    .i_cmp_a(cmp1_q),
    .i_period(per1_q),
    .o_count(cnt1),
    .o_evt(ev1),
    .o_pin(O_PIN_NARROW)
  );

  assign O_WB_DAT = rdat_q;
  assign O_WB_ACK = ack_q;
  assign O_WB_ERR = err_q;
endmodule

// >>> dv/ptm_chk.sv
// Bus protocol and readback checks on the timer pair's top ports
`timescale 1ns/1ps
module ptm_chk import ptm_pkg::*; (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [5:0] I_WB_ADR,
  input wire logic [31:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_WB_ERR
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // Steps of one bus cycle: a new request, then its answer
  sequence s_start;
    $rose(I_WB_CYC && I_WB_STB);
  endsequence
  sequence s_answer;
    O_WB_ACK || O_WB_ERR;
  endsequence
  a_req_answered: assert property (s_start |=> s_answer) else $error("request not answered");
  a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
    else $error("ack without request");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack held");
  a_err_pulse: assert property (O_WB_ERR |=> !O_WB_ERR) else $error("err held");
  a_ack_err_excl: assert property (!(O_WB_ACK && O_WB_ERR)) else $error("ack with err");
  a_err_zero_data: assert property (O_WB_ERR |-> O_WB_DAT == 32'h0) else $error("err data");
  // Unimplemented high bits of the period bytes must read zero
  a_narrow_hi_bits: assert property (O_WB_ACK && $past(!I_WB_WE && I_WB_ADR == PTM_ADR_PER1_HI)
    |-> O_WB_DAT[31:2] == 30'h0) else $error("narrow high byte");
  a_wide_hi_bits: assert property (O_WB_ACK && $past(!I_WB_WE && I_WB_ADR == PTM_ADR_PER0_HI)
    |-> O_WB_DAT[31:8] == 24'h0) else $error("wide high byte");
endmodule
bind ptm_top ptm_chk u_ptm_chk (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .O_WB_DAT(O_WB_DAT),
  .O_WB_ACK(O_WB_ACK), .O_WB_ERR(O_WB_ERR));

// >>> dv/tb_top.sv
// Self-checking bench for the periodic timer pair
`timescale 1ns/1ps
module tb_top import ptm_pkg::*; ;
  logic clk, rst, cyc, stb, we, ack, err, pw, pn, e, ce;
  logic [5:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd, c0;
  int bad_count, checks, hi, tg;
  ptm_top u_ptm_top (.I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .O_WB_ERR(err), .O_PIN_WIDE(pw), .O_PIN_NARROW(pn));
  // Free-running 100 MHz clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One classic cycle; held until ack or err is sampled, then one idle cycle
  // A slave that never answers is caught by the watchdog
  task automatic wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat; e = err;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(logic r, logic [1:0] m, a, logic l, i, c);
    return 32'(r) << PTM_B_RUN | 32'(m) << PTM_B_MODE | 32'(a) << PTM_B_ACT
      | 32'(l) << PTM_B_LVL | 32'(i) << PTM_B_INV | 32'(c) << PTM_B_CLR;
  endfunction
  // Stop first: action changes while running give undefined waveforms
  task automatic run(input logic [5:0] ca, input logic [1:0] m, a, input logic l, i, c);
    wb(ca, 1'b1, cw(1'b0, m, a, l, i, c));
    wb(ca, 1'b1, cw(1'b1, m, a, l, i, c));
    repeat (8) @(posedge clk);
  endtask
  task automatic meas(input int n, input logic nar);
    logic p, q;
    hi = 0; tg = 0; q = nar ? pn : pw;
    repeat (n) begin @(posedge clk); p = nar ? pn : pw; hi += p; tg += (p != q); q = p; end
  endtask
  task automatic flags(input logic [31:0] m, input logic [31:0] x);
    wb(PTM_ADR_FLAGS, 1'b1, 32'hF); repeat (20) @(posedge clk);
    wb(PTM_ADR_FLAGS, 1'b0, 0); check(rd & m, x);
  endtask
  task automatic t_regs();
    wb(PTM_ADR_CTRL0, 1'b0, 0); check(rd, 32'(PTM_CTRL_RST));
    wb(PTM_ADR_PER1_HI, 1'b1, 32'hFF); wb(PTM_ADR_PER1_HI, 1'b0, 0); check(rd, 32'h3);
    wb(PTM_ADR_PER0_HI, 1'b1, 32'hA5); wb(PTM_ADR_PER0_HI, 1'b0, 0); check(rd, 32'hA5);
    // Only the selected byte lane may change
    wb(PTM_ADR_CMPA0, 1'b1, 32'hFFFF); sel <= 4'h1;
    wb(PTM_ADR_CMPA0, 1'b1, 32'h1234); sel <= 4'hF;
    wb(PTM_ADR_CMPA0, 1'b0, 0); check(rd, 32'hFF34);
    wb(6'h3C, 1'b1, 32'h1); check({31'h0, e}, 32'h1);
    wb(6'h3C, 1'b0, 0); check(rd, 32'h0);
    wb(PTM_ADR_PER1_HI, 1'b1, 0); wb(PTM_ADR_PER0_HI, 1'b1, 0);
  endtask
  task automatic t_cmp();
    wb(PTM_ADR_CMPA0, 1'b1, 32'h4); run(PTM_ADR_CTRL0, 2'b00, 2'b11, 0, 0, 1);
    meas(40, 0); check(tg, 10);
    flags(32'h3, 32'h1);
    wb(PTM_ADR_PER0_LO, 1'b1, 32'h6); wb(PTM_ADR_CMPA0, 1'b1, 32'h3);
    run(PTM_ADR_CTRL0, 2'b00, 2'b11, 0, 0, 0); meas(60, 0); check(tg, 10);
    flags(32'h3, 32'h3);
    run(PTM_ADR_CTRL0, 2'b00, 2'b00, 1, 0, 0); meas(20, 0); check(hi, 20);
    check(tg, 0);
    run(PTM_ADR_CTRL0, 2'b11, 2'b11, 1, 0, 0); meas(20, 0); check(hi, 0);
    wb(PTM_ADR_CTRL0, 1'b1, 0); wb(PTM_ADR_CNT0, 1'b0, 0); c0 = rd;
    repeat (5) @(posedge clk); wb(PTM_ADR_CNT0, 1'b0, 0); check(rd, c0);
    // Period above any stale count; a stopped counter keeps its value
    wb(PTM_ADR_PER0_LO, 1'b1, 32'h6); wb(PTM_ADR_CMPA0, 1'b1, 32'h2);
    run(PTM_ADR_CTRL0, 2'b10, 2'b10, 1, 0, 0); meas(12, 0); check(hi, 4);
  endtask
  task automatic t_pwm();
    wb(PTM_ADR_PER1_LO, 1'b1, 32'h5); wb(PTM_ADR_CMPA1, 1'b1, 32'h2);
    run(PTM_ADR_CTRL1, 2'b10, 2'b10, 1, 0, 1); meas(20, 1); check(hi, 8);
    // Clock enable low freezes the running waveform
    ce <= 1'b0; @(posedge clk); meas(20, 1); check(tg, 0);
    ce <= 1'b1;
    flags(32'hC, 32'hC);
    run(PTM_ADR_CTRL1, 2'b10, 2'b10, 1, 1, 0); meas(20, 1); check(hi, 12);
    run(PTM_ADR_CTRL1, 2'b10, 2'b00, 1, 0, 0); meas(20, 1); check(hi, 0);
    flags(32'hC, 32'hC);
    run(PTM_ADR_CTRL1, 2'b10, 2'b01, 1, 0, 0); meas(20, 1); check(hi, 20);
    wb(PTM_ADR_CMPA1, 1'b1, 32'h7);
    run(PTM_ADR_CTRL1, 2'b10, 2'b10, 1, 0, 0); meas(20, 1); check(hi, 20);
    wb(PTM_ADR_PER1_LO, 1'b1, 0); wb(PTM_ADR_CMPA1, 1'b1, 32'h200);
    run(PTM_ADR_CTRL1, 2'b10, 2'b10, 1, 0, 0); meas(1024, 1); check(hi, 512);
    wb(PTM_ADR_CMPA1, 1'b1, 0); run(PTM_ADR_CTRL1, 2'b00, 2'b11, 0, 0, 0);
    wb(PTM_ADR_FLAGS, 1'b1, 32'hF); meas(1100, 1); check(tg, 0);
    wb(PTM_ADR_FLAGS, 1'b0, 0); check(rd & 32'hC, 32'h0);
  endtask
  // Two shots in a row: equal widths show the count restarts from zero
  task automatic t_pulse();
    wb(PTM_ADR_CMPA1, 1'b1, 32'h6); wb(PTM_ADR_CTRL1, 1'b1, cw(1'b0, 2'b10, 2'b11, 1, 0, 0));
    repeat (2) begin
      fork
        wb(PTM_ADR_CTRL1, 1'b1, cw(1'b1, 2'b10, 2'b11, 1, 0, 0));
        meas(40, 1);
      join
      check(hi, 6);
      wb(PTM_ADR_CTRL1, 1'b0, 0); check({31'h0, rd[PTM_B_RUN]}, 32'h0);
    end
    // Software stop ends the shot before the compare match
    fork
      begin
        wb(PTM_ADR_CTRL1, 1'b1, cw(1'b1, 2'b10, 2'b11, 1, 0, 0));
        wb(PTM_ADR_CTRL1, 1'b1, cw(1'b0, 2'b10, 2'b11, 1, 0, 0));
      end
      meas(40, 1);
    join
    check(hi, 3);
  endtask
  initial begin
    rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; wdat = 0; ce = 1;
    bad_count = 0; checks = 0;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs(); t_cmp(); t_pwm(); t_pulse();
    summarize();
  end
  // Hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #500000;
    bad_count++;
    summarize();
  end
endmodule
